// file: core/coding_pkg.sv
// Constants, types and code tables of the nibble to five-bit coding sublayer.
// Assumes one 100 MHz clock and a single-master AHB-Lite register bus.
// Function
// - Receive path buffers at least two groups before decoding or aligning.
// - Sublayer generates transmit and receive nibble clocks toward the MAC.
// - Each nibble becomes a five-bit group sent bit 4 first, bit 0 last.
// - Groups become receive nibbles only after start delimiter alignment.
// - Ten-bit window, position 0 newest, holds two groups once aligned.
// - Each new bit shifts the window toward oldest and enters position 0.
// - Code-bits leave one per 10 ns clock from the code-bit timer, its one-clock floor for the 8 ns figure.
// - After alignment a pulse marks each new group; bits 9 to 5 are current.
// - Transmit holds one group; serializer pulses when all its bits are sent.
// - Idle groups are sent at start-up and whenever no frame is sent.
// - Transmit enable starts J then K, ignoring the nibbles meanwhile.
// - After J and K, each nibble becomes one group until enable drops.
// - Transmit error during enable replaces data with the H group.
// - After enable drops, T then R are sent, then idles resume.
// - Collision is carrier received while transmitting.
// - Link state not OK forces transmit to idle at once.
// - Receiving marks non-idle input; transmitting marks the MAC sending.
// - Collector works bitwise until aligned, then signals every five bits.
// - Receive goes idle, carrier, confirm-K, then decodes to stream end.
// - Exactly sixteen groups are data and decode to their nibbles.
// - Idle 11111, J 11000, K 10001, T 01101, R 00111, H 00100.
// - Activity is two non-adjacent zeros within ten consecutive bits.
// - No delimiter after carrier gives error, nibble 1110 and no valid.
// - Carrier sense is receiving OR transmitting.
package coding_pkg;

	// Timer figures; the bit period may not fall below one clock.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CODE_BIT_NS = 8;
	localparam int unsigned BIT_CYCLES = (CODE_BIT_NS / CLK_PERIOD_NS < 1) ?
		1 : CODE_BIT_NS / CLK_PERIOD_NS;
	localparam logic [2:0] LAST_BIT = 3'h4;

	// Control groups and substituted nibbles.
	localparam logic [4:0] CG_IDLE = 5'h1f;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0d;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [4:0] CG_H = 5'h04;
	localparam logic [3:0] SSD_NIBBLE = 4'h5;
	localparam logic [3:0] FALSE_CARRIER_NIBBLE = 4'he;

	// Link states reported by the medium attachment.
	localparam logic [1:0] LINK_FAIL = 2'h0;
	localparam logic [1:0] LINK_READY = 2'h1;
	localparam logic [1:0] LINK_OK = 2'h2;

	// Register byte offsets, reset values and field positions.
	localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
	localparam logic [31:0] FALSE_CARRIER_OFS = 32'h0000_0008;
	localparam logic CTRL_RESET = 1'h0;
	localparam int unsigned CTRL_TX_INHIBIT_BIT = 0;

	typedef enum logic [5:0] {
		TX_IDLE = 6'h01,
		TX_J = 6'h02,
		TX_K = 6'h04,
		TX_DATA = 6'h08,
		TX_T = 6'h10,
		TX_R = 6'h20
	} tx_state_e;

	typedef enum logic [5:0] {
		RX_IDLE = 6'h01,
		RX_CARRIER = 6'h02,
		RX_CONFIRM_K = 6'h04,
		RX_DATA = 6'h08,
		RX_BAD_SSD = 6'h10,
		RX_LINK_FAIL = 6'h20
	} rx_state_e;

	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] d;
	} mii_tx_s;

	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] d;
	} mii_rx_s;

	typedef struct packed {
		logic [1:0] link;
		logic aligned;
		logic col;
		logic crs;
		logic receiving;
		logic transmitting;
	} status_s;

	// Nibble to data group.
	function automatic logic [4:0] encode_nibble(input logic [3:0] n);
		logic [4:0] g;
		case (n)
			4'h0: g = 5'h1e;
			4'h1: g = 5'h09;
			4'h2: g = 5'h14;
			4'h3: g = 5'h15;
			4'h4: g = 5'h0a;
			4'h5: g = 5'h0b;
			4'h6: g = 5'h0e;
			4'h7: g = 5'h0f;
			4'h8: g = 5'h12;
			4'h9: g = 5'h13;
			4'ha: g = 5'h16;
			4'hb: g = 5'h17;
			4'hc: g = 5'h1a;
			4'hd: g = 5'h1b;
			4'he: g = 5'h1c;
			default: g = 5'h1d;
		endcase
		return g;
	endfunction : encode_nibble

	// Group to {valid, nibble}; only the sixteen data groups are valid.
	function automatic logic [4:0] decode_group(input logic [4:0] g);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (encode_nibble(4'(i)) == g) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : decode_group

	// True when two zeros that are not neighbours sit in the window.
	function automatic logic has_activity(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!w[i] && !w[j]) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction : has_activity

endpackage : coding_pkg

// file: core/code_bit_serializer.sv
// Serializer that sends one held five-bit group per group period.
// Assumes the group input is stable at the edge of group_sent_pulse_out.
`timescale 1ns/1ps
`default_nettype none
module code_bit_serializer (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic [4:0] group_in,
	output wire logic tx_code_bit_out,
	output logic tx_clk_out,
	output wire logic group_sent_pulse_out
);

	logic [4:0] shift_q;
	logic [2:0] cnt_q;
	logic [7:0] pre_q;
	logic tick;

	// Code-bit timer; one tick per bit period.
	assign tick = (pre_q == 8'(coding_pkg::BIT_CYCLES - 1));
	assign group_sent_pulse_out = tick && (cnt_q == coding_pkg::LAST_BIT);
	assign tx_code_bit_out = shift_q[4];

	// Prescaler for the bit period.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pre_q <= 8'h00;
		end else if (tick) begin
			pre_q <= 8'h00;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end

	// Shift out msb first; reload the next group after bit 0 has gone.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			shift_q <= coding_pkg::CG_IDLE;
			cnt_q <= 3'h0;
		end else if (group_sent_pulse_out) begin
			shift_q <= group_in;
			cnt_q <= 3'h0;
		end else if (tick) begin
			shift_q <= {shift_q[3:0], 1'b0};
			cnt_q <= cnt_q + 3'h1;
		end
	end

	// Nibble clock: high for the first two bits so TXD settles well before the sample.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_clk_out <= 1'b0;
		end else if (tick) begin
			tx_clk_out <= (cnt_q == coding_pkg::LAST_BIT) || (cnt_q == 3'h0);
		end
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	property p_bit_order;
		group_sent_pulse_out |=> tx_code_bit_out == $past(group_in[4])
			##4 tx_code_bit_out == $past(group_in[0], 5);
	endproperty
	a_bit_order: assert property (p_bit_order) else $error("group bit order wrong");

	property p_group_period;
		group_sent_pulse_out |=> !group_sent_pulse_out[*4] ##1 group_sent_pulse_out;
	endproperty
	a_group_period: assert property (p_group_period) else $error("group period not five bits");

	c_sent: cover property (group_sent_pulse_out && group_in == coding_pkg::CG_J);

endmodule : code_bit_serializer
`default_nettype wire

// file: core/nibble_4b5b_coding_sublayer.sv
// Coding sublayer top: transmit framing, receive alignment and decoding, registers.
// Assumes AHB-Lite single master, a one-bit-per-strobe receive stream, and a
// link state input held synchronous to the clock.
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module nibble_4b5b_coding_sublayer (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic [31:0] hrdata_out,
	output logic hresp_out,
	input wire coding_pkg::mii_tx_s mii_tx_in,
	output coding_pkg::mii_rx_s mii_rx_out,
	output wire logic tx_clk_out,
	output logic rx_clk_out,
	output logic crs_out,
	output logic col_out,
	input wire logic [1:0] link_status_in,
	input wire logic rx_code_bit_in,
	input wire logic rx_bit_strobe_in,
	output wire logic tx_code_bit_out
);

	coding_pkg::tx_state_e tx_state_q;
	coding_pkg::rx_state_e rx_state_q;
	logic [4:0] tx_hold_q;
	logic transmitting_q;
	logic receiving_q;
	logic group_sent_pulse;
	logic group_received_pulse;
	logic [9:0] window_q;
	logic fresh_q;
	logic [2:0] rx_cnt_q;
	logic [4:0] cur_decode;
	logic link_ok;
	logic force_idle;
	logic tx_inhibit_q;
	logic [15:0] false_carrier_q;
	logic ahb_take;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	coding_pkg::status_s status;

	// Shift one bit into the window toward the oldest end.
	function automatic logic [9:0] window_shift_op(input logic [9:0] w,
		input logic b);
		return {w[8:0], b};
	endfunction : window_shift_op

	assign link_ok = (link_status_in == coding_pkg::LINK_OK);
	// Software inhibit shares the link-fail path so both give clean idles.
	assign force_idle = !link_ok || tx_inhibit_q;
	assign cur_decode = coding_pkg::decode_group(window_q[9:5]);

	code_bit_serializer u_ser (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.group_in(tx_hold_q),
		.tx_code_bit_out(tx_code_bit_out),
		.tx_clk_out(tx_clk_out),
		.group_sent_pulse_out(group_sent_pulse)
	);

	// Transmit machine; it chooses the group that follows the one in flight.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_state_q <= coding_pkg::TX_IDLE;
			tx_hold_q <= coding_pkg::CG_IDLE;
			transmitting_q <= 1'b0;
		end else if (force_idle) begin
			tx_state_q <= coding_pkg::TX_IDLE;
			tx_hold_q <= coding_pkg::CG_IDLE;
			transmitting_q <= 1'b0;
		end else if (group_sent_pulse) begin
			case (tx_state_q)
				coding_pkg::TX_IDLE: begin
					if (mii_tx_in.en) begin
						tx_state_q <= coding_pkg::TX_J;
						tx_hold_q <= coding_pkg::CG_J;
						transmitting_q <= 1'b1;
					end else begin
						tx_hold_q <= coding_pkg::CG_IDLE;
					end
				end
				coding_pkg::TX_J: begin
					tx_state_q <= coding_pkg::TX_K;
					tx_hold_q <= coding_pkg::CG_K;
				end
				coding_pkg::TX_K, coding_pkg::TX_DATA: begin
					if (mii_tx_in.en) begin
						tx_state_q <= coding_pkg::TX_DATA;
						if (mii_tx_in.er) begin
							tx_hold_q <= coding_pkg::CG_H;
						end else begin
							tx_hold_q <= coding_pkg::encode_nibble(mii_tx_in.d);
						end
					end else begin
						tx_state_q <= coding_pkg::TX_T;
						tx_hold_q <= coding_pkg::CG_T;
						transmitting_q <= 1'b0;
					end
				end
				coding_pkg::TX_T: begin
					tx_state_q <= coding_pkg::TX_R;
					tx_hold_q <= coding_pkg::CG_R;
				end
				default: begin
					tx_state_q <= coding_pkg::TX_IDLE;
					tx_hold_q <= coding_pkg::CG_IDLE;
				end
			endcase
		end
	end

	// Receive window; the machine below judges it the cycle after each bit.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			window_q <= 10'h3ff;
			fresh_q <= 1'b0;
		end else begin
			fresh_q <= rx_bit_strobe_in;
			if (rx_bit_strobe_in) begin
				window_q <= window_shift_op(window_q, rx_code_bit_in);
			end
		end
	end

	// Group counter restarts at the start delimiter; pulses only when aligned.
	assign group_received_pulse = fresh_q && (rx_cnt_q == coding_pkg::LAST_BIT) &&
		(rx_state_q == coding_pkg::RX_CONFIRM_K ||
		rx_state_q == coding_pkg::RX_DATA);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_cnt_q <= 3'h0;
			rx_clk_out <= 1'b0;
		end else if (fresh_q) begin
			if (rx_state_q == coding_pkg::RX_CARRIER ||
				rx_cnt_q == coding_pkg::LAST_BIT) begin
				rx_cnt_q <= 3'h0;
			end else begin
				rx_cnt_q <= rx_cnt_q + 3'h1;
			end
			// Rising edge falls two bits after the nibble changes.
			rx_clk_out <= (rx_cnt_q == 3'h1) || (rx_cnt_q == 3'h2);
		end
	end

	// Receive; carrier needs a new zero, so old T and R bits cannot retrigger.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_state_q <= coding_pkg::RX_IDLE;
			receiving_q <= 1'b0;
			mii_rx_out <= '0;
		end else if (!link_ok && receiving_q) begin
			rx_state_q <= coding_pkg::RX_LINK_FAIL;
			mii_rx_out <= '{dv: 1'b0, er: 1'b1, d: 4'h0};
		end else if (fresh_q || rx_state_q == coding_pkg::RX_LINK_FAIL ||
			rx_state_q == coding_pkg::RX_BAD_SSD) begin
			case (rx_state_q)
				coding_pkg::RX_IDLE: begin
					mii_rx_out <= '0;
					if (link_ok && !window_q[0] &&
						coding_pkg::has_activity(window_q)) begin
						rx_state_q <= coding_pkg::RX_CARRIER;
						receiving_q <= 1'b1;
					end
				end
				coding_pkg::RX_CARRIER: begin
					// Wait until the first zero reaches position 7 with ones above it.
					if (window_q[9:7] == 3'h6) begin
						if (window_q[9:5] == coding_pkg::CG_J) begin
							rx_state_q <= coding_pkg::RX_CONFIRM_K;
						end else begin
							rx_state_q <= coding_pkg::RX_BAD_SSD;
						end
					end else if (window_q[9:8] != 2'h3) begin
						rx_state_q <= coding_pkg::RX_BAD_SSD;
					end
				end
				coding_pkg::RX_CONFIRM_K: begin
					if (group_received_pulse) begin
						if (window_q[9:5] == coding_pkg::CG_K) begin
							rx_state_q <= coding_pkg::RX_DATA;
							mii_rx_out <= '{dv: 1'b1, er: 1'b0,
								d: coding_pkg::SSD_NIBBLE};
						end else begin
							rx_state_q <= coding_pkg::RX_BAD_SSD;
						end
					end
				end
				coding_pkg::RX_DATA: begin
					if (group_received_pulse) begin
						if (window_q == {coding_pkg::CG_T, coding_pkg::CG_R}) begin
							rx_state_q <= coding_pkg::RX_IDLE;
							receiving_q <= 1'b0;
							mii_rx_out <= '0;
						end else if (window_q == {coding_pkg::CG_IDLE,
							coding_pkg::CG_IDLE}) begin
							// Premature end: valid stays with error for one bit, until idle clears it.
							rx_state_q <= coding_pkg::RX_IDLE;
							receiving_q <= 1'b0;
							mii_rx_out <= '{dv: 1'b1, er: 1'b1, d: 4'h0};
						end else begin
							mii_rx_out <= '{dv: 1'b1, er: !cur_decode[4],
								d: cur_decode[3:0]};
						end
					end
				end
				coding_pkg::RX_BAD_SSD: begin
					// The false carrier ends on ten ones in a row, or on link loss through the branch above.
					if (window_q == 10'h3ff) begin
						rx_state_q <= coding_pkg::RX_IDLE;
						receiving_q <= 1'b0;
						mii_rx_out <= '0;
					end else begin
						mii_rx_out <= '{dv: 1'b0, er: 1'b1,
							d: coding_pkg::FALSE_CARRIER_NIBBLE};
					end
				end
				default: begin
					if (link_ok) begin
						rx_state_q <= coding_pkg::RX_IDLE;
						receiving_q <= 1'b0;
						mii_rx_out <= '0;
					end else begin
						mii_rx_out <= '{dv: 1'b0, er: 1'b1, d: 4'h0};
					end
				end
			endcase
		end
	end

	// Carrier sense and collision toward the MAC.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			crs_out <= 1'b0;
			col_out <= 1'b0;
		end else begin
			crs_out <= receiving_q || transmitting_q;
			col_out <= receiving_q && transmitting_q;
		end
	end

	// AHB-Lite slave with no wait states; reads are prepared in the address phase.
	assign ahb_take = hsel_in && htrans_in[1] && hready_in;
	assign status = '{link: link_status_in, aligned: mii_rx_out.dv,
		col: col_out, crs: crs_out, receiving: receiving_q,
		transmitting: transmitting_q};

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			hrdata_out <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
			wr_pend_q <= ahb_take && hwrite_in;
			wr_addr_q <= {haddr_in[31:2], 2'h0};
			hrdata_out <= 32'h0000_0000;
			if (ahb_take && !hwrite_in) begin
				if ({haddr_in[31:2], 2'h0} == coding_pkg::CTRL_OFS) begin
					hrdata_out <= {31'h0000_0000, tx_inhibit_q};
				end else if ({haddr_in[31:2], 2'h0} == coding_pkg::STATUS_OFS) begin
					hrdata_out <= {25'h000_0000, status};
				end else if ({haddr_in[31:2], 2'h0} ==
					coding_pkg::FALSE_CARRIER_OFS) begin
					hrdata_out <= {16'h0000, false_carrier_q};
				end
			end
		end
	end

	// Control register and false-carrier count; a new event beats a clear.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_inhibit_q <= coding_pkg::CTRL_RESET;
			false_carrier_q <= 16'h0000;
		end else begin
			if (wr_pend_q && wr_addr_q == coding_pkg::CTRL_OFS) begin
				tx_inhibit_q <= hwdata_in[coding_pkg::CTRL_TX_INHIBIT_BIT];
			end
			if (fresh_q && rx_state_q == coding_pkg::RX_CARRIER &&
				link_ok && (window_q[9:8] != 2'h3 || (window_q[9:7] == 3'h6 &&
				window_q[9:5] != coding_pkg::CG_J))) begin
				if (wr_pend_q && wr_addr_q == coding_pkg::FALSE_CARRIER_OFS) begin
					false_carrier_q <= 16'h0001;
				end else if (false_carrier_q != 16'hffff) begin
					false_carrier_q <= false_carrier_q + 16'h0001;
				end
			end else if (wr_pend_q && wr_addr_q == coding_pkg::FALSE_CARRIER_OFS) begin
				false_carrier_q <= 16'h0000;
			end
		end
	end

	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);

	property p_link_idle;
		!link_ok |=> tx_state_q == coding_pkg::TX_IDLE &&
			tx_hold_q == coding_pkg::CG_IDLE && !transmitting_q;
	endproperty
	a_link_idle: assert property (p_link_idle) else $error("tx not idle on link loss");

	property p_ssd_start;
		tx_state_q == coding_pkg::TX_IDLE && group_sent_pulse && mii_tx_in.en &&
			!force_idle |=> tx_hold_q == coding_pkg::CG_J;
	endproperty
	a_ssd_start: assert property (p_ssd_start) else $error("J not sent on enable");

	property p_tx_error;
		(tx_state_q == coding_pkg::TX_K || tx_state_q == coding_pkg::TX_DATA) &&
			group_sent_pulse && mii_tx_in.en && mii_tx_in.er && !force_idle
			|=> tx_hold_q == coding_pkg::CG_H;
	endproperty
	a_tx_error: assert property (p_tx_error) else $error("H not sent on error");

	property p_esd;
		tx_state_q == coding_pkg::TX_T && group_sent_pulse && !force_idle
			|=> tx_hold_q == coding_pkg::CG_R && tx_state_q == coding_pkg::TX_R;
	endproperty
	a_esd: assert property (p_esd) else $error("R does not follow T");

	property p_crs;
		receiving_q || transmitting_q |=> crs_out;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier sense missing");

	property p_col;
		receiving_q && transmitting_q |=> col_out;
	endproperty
	a_col: assert property (p_col) else $error("collision not flagged");

	property p_false_carrier;
		rx_state_q == coding_pkg::RX_BAD_SSD && $past(rx_state_q) ==
			coding_pkg::RX_BAD_SSD |-> mii_rx_out.er && !mii_rx_out.dv &&
			mii_rx_out.d == coding_pkg::FALSE_CARRIER_NIBBLE;
	endproperty
	a_false_carrier: assert property (p_false_carrier) else $error("bad false carrier");

	property p_group_spacing;
		group_received_pulse |=> !group_received_pulse[*4];
	endproperty
	a_group_spacing: assert property (p_group_spacing) else $error("group pulse too soon");

	property p_window_shift;
		rx_bit_strobe_in |=> window_q == {$past(window_q[8:0]), $past(rx_code_bit_in)};
	endproperty
	a_window_shift: assert property (p_window_shift) else $error("window shift wrong");

	c_frame_end: cover property (tx_state_q == coding_pkg::TX_R);
	c_aligned: cover property (rx_state_q == coding_pkg::RX_DATA && mii_rx_out.dv);
	c_bad_ssd: cover property (rx_state_q == coding_pkg::RX_BAD_SSD);
	c_collision: cover property (col_out);

endmodule : nibble_4b5b_coding_sublayer
`default_nettype wire

// file: tb/mac_model.sv
// Nibble-side client model: sends one frame of counting nibbles on request.
// Assumes the transmit clock rises once per group, before nibbles are taken.
`timescale 1ns/1ps
`default_nettype none
module mac_model (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic tx_clk_in,
	input wire logic go_in,
	input wire logic [3:0] len_in,
	input wire logic [3:0] err_at_in,
	output coding_pkg::mii_tx_s mii_tx_out
);
	logic clk_q;
	logic pend_q;
	logic [3:0] cnt_q;
	// Nibbles change just after the transmit clock rises. A released data
	// bus shows the inverse of its last value, so stale data cannot pass.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_q <= 1'b0;
			pend_q <= 1'b0;
			cnt_q <= 4'h0;
			mii_tx_out <= '0;
		end else begin
			clk_q <= tx_clk_in;
			if (tx_clk_in && !clk_q) begin
				if (mii_tx_out.en && cnt_q == len_in) begin
					mii_tx_out <= {2'b00, ~mii_tx_out.d};
				end else if (mii_tx_out.en) begin
					mii_tx_out <= {1'b1, cnt_q == err_at_in, cnt_q};
					cnt_q <= cnt_q + 4'h1;
				end else if (pend_q) begin
					mii_tx_out <= {2'b10, 4'h0};
					cnt_q <= 4'h1;
					pend_q <= 1'b0;
				end
			end
			if (go_in) begin
				pend_q <= 1'b1;
			end
		end
	end
endmodule : mac_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the coding sublayer: framing, alignment, registers.
// Assumes the sublayer answers bus requests without wait states.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hready;
	logic [31:0] hrdata;
	logic hresp;
	coding_pkg::mii_tx_s mii_tx;
	coding_pkg::mii_rx_s mii_rx;
	logic tx_clk, rx_clk, rx_clk_q, crs, col, txb, go = 1'b0;
	logic [1:0] link = coding_pkg::LINK_OK;
	logic rxb = 1'b1;
	logic rxs = 1'b0;
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	logic col_seen = 1'b0;
	logic fc_seen = 1'b0;
	logic [3:0] rxq[$];
	logic [31:0] rd;
	logic [4:0] enc[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
		5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	nibble_4b5b_coding_sublayer uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
		.hresp_out(hresp), .mii_tx_in(mii_tx), .mii_rx_out(mii_rx),
		.tx_clk_out(tx_clk), .rx_clk_out(rx_clk), .crs_out(crs),
		.col_out(col), .link_status_in(link), .rx_code_bit_in(rxb),
		.rx_bit_strobe_in(rxs), .tx_code_bit_out(txb));
	mac_model mac (.mclk_in(mclk_in), .rstn_in(rstn_in), .tx_clk_in(tx_clk),
		.go_in(go), .len_in(4'ha), .err_at_in(4'h6), .mii_tx_out(mii_tx));
	// Free-running 100 MHz clock.
	always #5 mclk_in = ~mclk_in;
	// Watches nibbles at each receive clock rise, collisions, false carriers.
	always @(posedge mclk_in) begin
		rx_clk_q <= rx_clk;
		if (rx_clk && !rx_clk_q && mii_rx.dv) rxq.push_back(mii_rx.d);
		if (col) col_seen = 1'b1;
		if (mii_rx.er && !mii_rx.dv && mii_rx.d == 4'he) fc_seen = 1'b1;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// Single word transfer; entered just after a rising edge.
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] wd);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk_in); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	// The medium side sends one group, bit 4 first, a strobe every cycle.
	task automatic rx_group(input logic [4:0] g);
		for (int i = 4; i >= 0; i--) begin
			rxb <= g[i];
			rxs <= 1'b1;
			@(posedge mclk_in);
		end
	endtask : rx_group
	// Collects one transmitted group from the code-bit line.
	task automatic tx_group(output logic [4:0] g);
		repeat (5) begin
			@(posedge mclk_in);
			g = {g[3:0], txb};
		end
	endtask : tx_group
	// Waits for the start delimiter on the transmit line, bounded.
	task automatic tx_sync();
		logic [9:0] sr = '1;
		for (int k = 0; k < 300 && sr !== {coding_pkg::CG_J, coding_pkg::CG_K};
			k++) begin
			@(posedge mclk_in);
			sr = {sr[8:0], txb};
		end
		`CHK("start delimiter", {coding_pkg::CG_J, coding_pkg::CG_K}, sr)
	endtask : tx_sync
	task automatic start_frame();
		go <= 1'b1;
		@(posedge mclk_in);
		go <= 1'b0;
	endtask : start_frame
	// Reset state and control register default, unmapped read.
	task automatic t_reset();
		`CHK("tx idle bit", 1'b1, txb)
		`CHK("rx nibble", 6'h00, mii_rx)
		`CHK("carrier", 1'b0, crs)
		`CHK("hresp", 1'b0, hresp)
		ahb(1'b0, coding_pkg::CTRL_OFS, '0);
		`CHK("ctrl", 32'h0000_0000, rd)
		ahb(1'b0, 32'h0000_000c, '0);
		`CHK("unmapped", 32'h0000_0000, rd)
	endtask : t_reset
	// Frame out with an error nibble while a frame comes in: collision.
	task automatic t_frame();
		logic [4:0] g;
		start_frame();
		fork
			begin
				tx_sync();
				for (int i = 2; i < 10; i++) begin
					tx_group(g);
					`CHK("tx group", i == 6 ? coding_pkg::CG_H : enc[i], g)
				end
				tx_group(g);
				`CHK("tx end 1", coding_pkg::CG_T, g)
				tx_group(g);
				`CHK("tx end 2", coding_pkg::CG_R, g)
				tx_group(g);
				`CHK("tx idle", coding_pkg::CG_IDLE, g)
			end
			begin
				repeat (4) rx_group(coding_pkg::CG_IDLE);
				rx_group(coding_pkg::CG_J);
				rx_group(coding_pkg::CG_K);
				rx_group(enc[3]);
				rx_group(enc[9]);
				rx_group(enc[12]);
				rx_group(coding_pkg::CG_T);
				rx_group(coding_pkg::CG_R);
				repeat (4) rx_group(coding_pkg::CG_IDLE);
				rxs <= 1'b0;
			end
		join
		repeat (20) @(posedge mclk_in);
		`CHK("rx count", 4, rxq.size())
		`CHK("rx 0", 4'h5, rxq[0])
		`CHK("rx 1", 4'h3, rxq[1])
		`CHK("rx 2", 4'h9, rxq[2])
		`CHK("rx 3", 4'hc, rxq[3])
		`CHK("collision", 1'b1, col_seen)
		`CHK("carrier off", 1'b0, crs)
	endtask : t_frame
	// Activity without a start delimiter, then the count register.
	task automatic t_false_carrier();
		repeat (2) rx_group(coding_pkg::CG_IDLE);
		repeat (2) rx_group(5'h15);
		repeat (4) rx_group(coding_pkg::CG_IDLE);
		rxs <= 1'b0;
		`CHK("false carrier", 1'b1, fc_seen)
		ahb(1'b0, coding_pkg::FALSE_CARRIER_OFS, '0);
		`CHK("fc count", 32'h0000_0001, rd)
	endtask : t_false_carrier
	// Link loss mid-frame and the inhibit bit both force idle groups.
	task automatic t_idle_force(input logic by_link);
		logic [4:0] g;
		if (!by_link) ahb(1'b1, coding_pkg::CTRL_OFS, 32'h0000_0001);
		start_frame();
		if (by_link) tx_sync();
		link <= by_link ? coding_pkg::LINK_READY : coding_pkg::LINK_OK;
		repeat (2) tx_group(g);
		repeat (4) begin
			tx_group(g);
			`CHK("forced idle", coding_pkg::CG_IDLE, g)
		end
		ahb(1'b0, coding_pkg::STATUS_OFS, '0);
		`CHK("status link", by_link ? 2'h1 : 2'h2, rd[6:5])
		link <= coding_pkg::LINK_OK;
		ahb(1'b1, coding_pkg::CTRL_OFS, 32'h0000_0000);
		repeat (80) @(posedge mclk_in);
	endtask : t_idle_force
	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// Main sequence.
	initial begin
		repeat (16) @(posedge mclk_in);
		rstn_in <= 1'b1;
		@(posedge mclk_in);
		t_reset();
		t_frame();
		t_false_carrier();
		t_idle_force(1'b1);
		t_idle_force(1'b0);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
